/* rtl/vcg_pkg.sv */
package vcg_pkg;
  // register byte offsets on the serial control port
  localparam logic [7:0] ADDR_CLAMP_DELAY = 8'h05;
  localparam logic [7:0] ADDR_CLAMP_LENGTH = 8'h06;
  localparam logic [7:0] ADDR_RED_FULL_SCALE = 8'h08;
  localparam logic [7:0] ADDR_GREEN_FULL_SCALE = 8'h09;
  localparam logic [7:0] ADDR_BLUE_FULL_SCALE = 8'h0a;
  localparam logic [7:0] ADDR_RED_LEVEL_SHIFT = 8'h0b;
  localparam logic [7:0] ADDR_GREEN_LEVEL_SHIFT = 8'h0c;
  localparam logic [7:0] ADDR_BLUE_LEVEL_SHIFT = 8'h0d;
  localparam logic [7:0] ADDR_CLAMP_CTRL = 8'h0f;
  localparam logic [7:0] ADDR_CLAMP_SEL = 8'h10;
  // field positions
  localparam int CLAMP_POL_BIT = 6;
  localparam int CLAMP_SRC_BIT = 7;
  localparam int RED_MID_BIT = 1;
  localparam int BLUE_MID_BIT = 2;
  localparam int SOG_THR_LSB = 3;
  localparam int SOG_THR_W = 5;
  // reset values
  localparam logic [7:0] CLAMP_DELAY_RST = 8'h08;
  localparam logic [7:0] CLAMP_LENGTH_RST = 8'h14;
  localparam logic [7:0] FULL_SCALE_RST = 8'h80;
  localparam logic [6:0] LEVEL_SHIFT_RST = 7'h40;
  localparam logic [7:0] CLAMP_CTRL_RST = 8'h00;
  localparam logic [7:0] CLAMP_SEL_RST = 8'h78;
  // clamp target codes
  localparam logic [7:0] CODE_GROUND = 8'h00;
  localparam logic [7:0] CODE_MIDSCALE = 8'h80;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CLAMP} vcg_state_e;
endpackage : vcg_pkg

/* rtl/vcg_offset_loop.sv */
`timescale 1ns/1ps
// per-channel black-level servo: nudges a correction while clamping
module vcg_offset_loop (
  input wire logic clock, // pixel clock
  input wire logic srst, // sync reset
  input wire logic clamp_active, // clamp window
  input wire logic [7:0] target_code, // code black should convert to
  input wire logic [7:0] sample_code, // digitizer output
  output logic [7:0] correction // held correction, midpoint 0x80
);
  // step one code per clamp cycle; value is held between windows
  always_ff @(posedge clock)
  begin
    if (srst)
      correction <= vcg_pkg::CODE_MIDSCALE;
    else if (clamp_active && sample_code > target_code && correction != 8'h00)
      correction <= correction - 8'h01;
    else if (clamp_active && sample_code < target_code && correction != 8'hff)
      correction <= correction + 8'h01;
  end

  a_hold_outside: assert property (@(posedge clock) disable iff (srst)
    !$past(clamp_active) |-> $stable(correction))
    else $error("correction moved outside clamp window");
endmodule : vcg_offset_loop

/* rtl/vcg_clamp_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - source bit one selects external clamp pin
// - external clamp polarity from 0x0F bit 6
// - wait delay pixels after sync trailing edge
// - clamp stays active for length pixels
// - delay and length are full 8-bit
// - ground clamp drives black to 0x00, held
// - red, blue select midscale or ground
// - three 8-bit gains set full scale
// - three 7-bit offsets, plus/minus 63 steps
// - sync-on-green threshold field in 0x10
// - green embedded sync always active low
module vcg_clamp_ctrl (
  input wire logic clock, // pixel clock
  input wire logic srst, // sync reset
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data
  input wire logic line_sync, // line sync, active high
  input wire logic green_embedded_sync_input, // sliced green sync, active low
  input wire logic ext_clamp, // external clamp pin
  input wire logic [23:0] sample_rgb, // digitizer codes b,g,r
  output logic clamp, // clamp window to front end
  output logic [2:0] clamp_mid, // per channel midscale clamp b,g,r
  output logic red_midlevel_reference_pin, // red midscale reference enable
  output logic blue_midlevel_reference_pin, // blue midscale reference enable
  output logic [23:0] full_scale, // gains b,g,r
  output logic [20:0] level_shift, // offsets b,g,r
  output logic [23:0] black_correction, // clamp servo values b,g,r
  output logic [4:0] sog_threshold, // slicer threshold code
  output logic line_sync_sel // effective sync, active high
);
  logic [7:0] clamp_delay_r;
  logic [7:0] clamp_length_r;
  logic [7:0] gain_r [3];
  logic [6:0] shift_r [3];
  logic [7:0] clamp_ctrl_r;
  logic [7:0] clamp_sel_r;
  logic sync_d_r;
  logic [7:0] cnt_r;
  vcg_pkg::vcg_state_e state_r;
  logic int_clamp;
  logic ext_active;
  logic sync_trail;
  logic [7:0] tgt [3];

  // register writes; level shifts held at 7 bits, all other fields at full width
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      clamp_delay_r <= vcg_pkg::CLAMP_DELAY_RST;
      clamp_length_r <= vcg_pkg::CLAMP_LENGTH_RST;
      clamp_ctrl_r <= vcg_pkg::CLAMP_CTRL_RST;
      clamp_sel_r <= vcg_pkg::CLAMP_SEL_RST;
      for (int i = 0; i < 3; i++)
      begin
        gain_r[i] <= vcg_pkg::FULL_SCALE_RST;
        shift_r[i] <= vcg_pkg::LEVEL_SHIFT_RST;
      end
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        vcg_pkg::ADDR_CLAMP_DELAY: clamp_delay_r <= reg_wdata;
        vcg_pkg::ADDR_CLAMP_LENGTH: clamp_length_r <= reg_wdata;
        vcg_pkg::ADDR_RED_FULL_SCALE: gain_r[0] <= reg_wdata;
        vcg_pkg::ADDR_GREEN_FULL_SCALE: gain_r[1] <= reg_wdata;
        vcg_pkg::ADDR_BLUE_FULL_SCALE: gain_r[2] <= reg_wdata;
        vcg_pkg::ADDR_RED_LEVEL_SHIFT: shift_r[0] <= reg_wdata[6:0];
        vcg_pkg::ADDR_GREEN_LEVEL_SHIFT: shift_r[1] <= reg_wdata[6:0];
        vcg_pkg::ADDR_BLUE_LEVEL_SHIFT: shift_r[2] <= reg_wdata[6:0];
        vcg_pkg::ADDR_CLAMP_CTRL: clamp_ctrl_r <= reg_wdata;
        vcg_pkg::ADDR_CLAMP_SEL: clamp_sel_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // registered read port; unmapped addresses read zero
  always_ff @(posedge clock)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        vcg_pkg::ADDR_CLAMP_DELAY: reg_rdata <= clamp_delay_r;
        vcg_pkg::ADDR_CLAMP_LENGTH: reg_rdata <= clamp_length_r;
        vcg_pkg::ADDR_RED_FULL_SCALE: reg_rdata <= gain_r[0];
        vcg_pkg::ADDR_GREEN_FULL_SCALE: reg_rdata <= gain_r[1];
        vcg_pkg::ADDR_BLUE_FULL_SCALE: reg_rdata <= gain_r[2];
        vcg_pkg::ADDR_RED_LEVEL_SHIFT: reg_rdata <= {1'b0, shift_r[0]};
        vcg_pkg::ADDR_GREEN_LEVEL_SHIFT: reg_rdata <= {1'b0, shift_r[1]};
        vcg_pkg::ADDR_BLUE_LEVEL_SHIFT: reg_rdata <= {1'b0, shift_r[2]};
        vcg_pkg::ADDR_CLAMP_CTRL: reg_rdata <= clamp_ctrl_r;
        vcg_pkg::ADDR_CLAMP_SEL: reg_rdata <= clamp_sel_r;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // green sync has no polarity option: low means sync
  assign line_sync_sel = line_sync | ~green_embedded_sync_input;

  // trailing edge of line sync
  always_ff @(posedge clock)
  begin
    if (srst)
      sync_d_r <= 1'b0;
    else
      sync_d_r <= line_sync_sel;
  end
  assign sync_trail = sync_d_r & ~line_sync_sel;

  // internal clamp timer; a fresh edge always restarts it so a short line
  // cannot leave a stale window running
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_r <= vcg_pkg::ST_IDLE;
      cnt_r <= 8'h00;
    end
    else if (sync_trail)
    begin
      cnt_r <= 8'h00;
      if (clamp_delay_r != 8'h00)
        state_r <= vcg_pkg::ST_DELAY;
      else if (clamp_length_r != 8'h00)
        state_r <= vcg_pkg::ST_CLAMP;
      else
        state_r <= vcg_pkg::ST_IDLE;
    end
    else
    begin
      case (state_r)
        vcg_pkg::ST_DELAY:
        begin
          if (cnt_r == clamp_delay_r - 8'h01)
          begin
            cnt_r <= 8'h00;
            state_r <= (clamp_length_r != 8'h00) ? vcg_pkg::ST_CLAMP : vcg_pkg::ST_IDLE;
          end
          else
            cnt_r <= cnt_r + 8'h01;
        end
        vcg_pkg::ST_CLAMP:
        begin
          if (cnt_r == clamp_length_r - 8'h01)
          begin
            cnt_r <= 8'h00;
            state_r <= vcg_pkg::ST_IDLE;
          end
          else
            cnt_r <= cnt_r + 8'h01;
        end
        vcg_pkg::ST_IDLE: cnt_r <= 8'h00;
        default: state_r <= vcg_pkg::ST_IDLE;
      endcase
    end
  end
  assign int_clamp = (state_r == vcg_pkg::ST_CLAMP);

  // external pin, active level chosen by polarity bit (1 = active high)
  assign ext_active = ext_clamp ~^ clamp_ctrl_r[vcg_pkg::CLAMP_POL_BIT];
  assign clamp = clamp_ctrl_r[vcg_pkg::CLAMP_SRC_BIT] ? ext_active : int_clamp;

  // clamp targets: green always ground, red and blue selectable
  assign clamp_mid = {clamp_sel_r[vcg_pkg::BLUE_MID_BIT], 1'b0,
                      clamp_sel_r[vcg_pkg::RED_MID_BIT]};
  assign red_midlevel_reference_pin = clamp_sel_r[vcg_pkg::RED_MID_BIT];
  assign blue_midlevel_reference_pin = clamp_sel_r[vcg_pkg::BLUE_MID_BIT];
  assign sog_threshold = clamp_sel_r[vcg_pkg::SOG_THR_LSB +: vcg_pkg::SOG_THR_W];

  // per-channel settings and servo
  generate
    for (genvar c = 0; c < 3; c++)
    begin : g_chan
      assign full_scale[8*c +: 8] = gain_r[c];
      assign level_shift[7*c +: 7] = shift_r[c];
      assign tgt[c] = clamp_mid[c] ? vcg_pkg::CODE_MIDSCALE : vcg_pkg::CODE_GROUND;
      vcg_offset_loop u_loop (
        .clock(clock),
        .srst(srst),
        .clamp_active(clamp),
        .target_code(tgt[c]),
        .sample_code(sample_rgb[8*c +: 8]),
        .correction(black_correction[8*c +: 8])
      );
    end
  endgenerate

  sequence s_trail_int;
    sync_trail && !clamp_ctrl_r[vcg_pkg::CLAMP_SRC_BIT] && clamp_delay_r == 8'h08
      && clamp_length_r == 8'h14;
  endsequence

  a_ext_source: assert property (@(posedge clock) disable iff (srst)
    clamp_ctrl_r[vcg_pkg::CLAMP_SRC_BIT] |-> clamp == ext_active)
    else $error("external clamp not selected");
  a_ext_polarity: assert property (@(posedge clock) disable iff (srst)
    clamp_ctrl_r[7:6] == 2'b10 |-> clamp == ~ext_clamp)
    else $error("clamp polarity wrong");
  // the edge that counts out the delay is the eighth after the trailing edge,
  // so the window is seen one edge later
  a_delay_wait: assert property (@(posedge clock) disable iff (srst)
    s_trail_int ##1 (!sync_trail && !clamp_ctrl_r[7])[*8] |=> int_clamp)
    else $error("clamp did not start after delay");
  a_early_clamp: assert property (@(posedge clock) disable iff (srst)
    s_trail_int ##1 (!sync_trail && !clamp_ctrl_r[7])[*8] |-> !clamp)
    else $error("clamp started early");
  a_len_count: assert property (@(posedge clock) disable iff (srst)
    $rose(int_clamp) && clamp_length_r == 8'h14 && clamp_delay_r == 8'h08
      ##19 !sync_trail |-> int_clamp ##1 (!int_clamp || $past(sync_trail)))
    else $error("clamp length wrong");
  a_cnt_restart: assert property (@(posedge clock) disable iff (srst)
    sync_trail |=> cnt_r == 8'h00)
    else $error("counter not restarted");
  a_wide_delay: assert property (@(posedge clock) disable iff (srst)
    state_r == vcg_pkg::ST_DELAY |-> cnt_r < clamp_delay_r)
    else $error("delay count overflow");
  a_mid_target: assert property (@(posedge clock) disable iff (srst)
    tgt[0] == (clamp_sel_r[vcg_pkg::RED_MID_BIT] ? 8'h80 : 8'h00))
    else $error("red clamp target wrong");
  a_sog_low: assert property (@(posedge clock) disable iff (srst)
    !green_embedded_sync_input |-> line_sync_sel)
    else $error("green sync polarity");
endmodule : vcg_clamp_ctrl

/* tb/vcg_video_source.sv */
`timescale 1ns/1ps
// graphics source: one short sync pulse per request, flat black level
module vcg_video_source (
  input wire logic clock, // pixel clock
  input wire logic sync_go, // start one sync pulse
  input wire logic on_green, // embed sync on green instead
  output logic line_sync, // separate sync, high in pulse
  output logic green_sync_n, // green sync, low in pulse
  output logic [23:0] sample_rgb // digitized black level
);
  logic [2:0] left_r = 3'h0;
  // four pixel pulse; both sync lines sit idle between lines
  always_ff @(posedge clock)
    if (sync_go)
      left_r <= #1 3'h4;
    else if (left_r != 3'h0)
      left_r <= #1 left_r - 3'h1;
  assign line_sync = !on_green && left_r != 3'h0;
  assign green_sync_n = !(on_green && left_r != 3'h0);
  // black sits off ground so the servo always has work
  assign sample_rgb = 24'h30_3030;
endmodule : vcg_video_source

/* tb/testbench.sv */
`timescale 1ns/1ps
// register, clamp timing and black servo checks
module testbench;
  logic clock, srst, reg_wr, reg_rd, ext_clamp, sync_go, on_green, line_sync, clamp;
  logic green_embedded_sync_input, red_midlevel_reference_pin, blue_midlevel_reference_pin;
  logic line_sync_sel;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rval, v, c0;
  logic [23:0] sample_rgb, full_scale, black_correction;
  logic [20:0] level_shift;
  logic [2:0] clamp_mid;
  logic [4:0] sog_threshold;
  int n_errors = 0, checked = 0, first, len, dg;
  logic [7:0] addr_t [10] = '{8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d,
    8'h0f, 8'h10};
  logic [7:0] rst_t [10] = '{8'h08, 8'h14, 8'h80, 8'h80, 8'h80, 8'h40, 8'h40, 8'h40, 8'h00, 8'h78};
  // control registers keep all eight bits, only the level shifts are 7-bit
  logic [7:0] msk_t [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'h7f, 8'hff, 8'hff};
  logic [7:0] dly_t [4] = '{8'h08, 8'h00, 8'hff, 8'h05};
  logic [7:0] len_t [4] = '{8'h14, 8'h01, 8'hff, 8'h00};

  vcg_clamp_ctrl i_vcg_clamp_ctrl (.clock, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .line_sync, .green_embedded_sync_input, .ext_clamp, .sample_rgb, .clamp,
    .clamp_mid, .red_midlevel_reference_pin, .blue_midlevel_reference_pin, .full_scale,
    .level_shift, .black_correction, .sog_threshold, .line_sync_sel);
  vcg_video_source i_vcg_video_source (.clock, .sync_go, .on_green, .line_sync,
    .green_sync_n(green_embedded_sync_input), .sample_rgb);

  task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // strobes rise just after an edge and drop after the taking edge
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock) #1;
    reg_wr = 1'b0;
  endtask : wr

  task automatic read_reg(logic [7:0] a, output logic [7:0] d);
    @(posedge clock) #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock) #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : read_reg

  task automatic pulse();
    @(posedge clock) #1;
    sync_go = 1'b1;
    @(posedge clock) #1;
    sync_go = 1'b0;
  endtask : pulse

  // window covers the longest delay plus length with margin
  task automatic run_line(output int f, output int l);
    f = -1;
    l = 0;
    pulse();
    wait (line_sync_sel === 1'b1);
    wait (line_sync_sel === 1'b0);
    // sample 1 follows the edge that sees the fall, so delay D shows as D + 1
    for (int i = 1; i <= 520; i++)
    begin
      @(posedge clock) #1;
      if (clamp === 1'b1)
      begin
        if (f < 0)
          f = i;
        l++;
      end
    end
  endtask : run_line

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // hang guard, far beyond the few thousand cycles needed
  initial
  begin
    #500000;
    n_errors++;
    final_report();
  end

  initial
  begin
    {srst, reg_wr, reg_rd, ext_clamp, sync_go, on_green} = 6'h20;
    {reg_addr, reg_wdata} = 16'h0000;
    repeat (3) @(posedge clock);
    #1 srst = 1'b0;
    check("clamp_idle", clamp, 24'h0);
    check("sync_idle", line_sync_sel, 24'h0);
    for (int i = 0; i < 10; i++)
    begin
      read_reg(addr_t[i], rval);
      check("reset_value", rval, rst_t[i]);
    end
    wr(8'h05, 8'h08);
    wr(8'h06, 8'h14);
    c0 = black_correction[7:0];
    run_line(first, len);
    dg = int'(black_correction[7:0]) - int'(c0);
    check("servo_all", black_correction, 24'h6c_6c6c);
    check("servo_step", 24'(dg < 0 ? -dg : dg), 24'h14);
    c0 = black_correction[7:0];
    repeat (20) @(posedge clock);
    check("servo_hold", black_correction[7:0], c0);
    wr(8'h10, 8'h7a);
    run_line(first, len);
    check("servo_mid", 24'(int'(black_correction[7:0]) - int'(c0)), 24'(-dg));
    check("servo_sel", black_correction, 24'h58_5880);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h05, dly_t[i]);
      wr(8'h06, len_t[i]);
      run_line(first, len);
      check("start", 24'(first), len_t[i] == 0 ? 24'hff_ffff : dly_t[i] + 24'h1);
      check("length", 24'(len), len_t[i]);
    end
    on_green = 1'b1;
    wr(8'h05, 8'h03);
    wr(8'h06, 8'h02);
    run_line(first, len);
    check("green_start", 24'(first), 24'h4);
    check("green_len", 24'(len), 24'h2);
    on_green = 1'b0;
    wr(8'h05, 8'h40);
    wr(8'h06, 8'h08);
    pulse();
    repeat (6) @(posedge clock);
    run_line(first, len);
    check("restart", 24'(first), 24'h41);
    for (int p = 0; p < 2; p++)
      for (int e = 0; e < 2; e++)
      begin
        wr(8'h0f, p ? 8'hc0 : 8'h80);
        ext_clamp = e[0];
        @(posedge clock) #1;
        check("ext_clamp", clamp, p ? e[0] : !e[0]);
      end
    for (int k = 0; k < 2; k++)
    begin
      v = k ? 8'h5a : 8'ha5;
      for (int i = 0; i < 10; i++)
        wr(addr_t[i], v);
      for (int i = 0; i < 10; i++)
      begin
        read_reg(addr_t[i], rval);
        check("readback", rval, v & msk_t[i]);
      end
      check("full_scale", full_scale, {3{v}});
      check("level_shift", level_shift, {3{v[6:0]}});
      check("sog_threshold", sog_threshold, v[7:3]);
      check("mid_sel", {clamp_mid, red_midlevel_reference_pin, blue_midlevel_reference_pin},
        {v[2], 1'b0, v[1], v[1], v[2]});
    end
    wr(8'h07, 8'hff);
    read_reg(8'h07, rval);
    check("unmapped", rval, 8'h00);
    final_report();
  end
endmodule : testbench
